// >>> src/jms_pkg.sv
// Shared constants and carrier types for the master port select block.
// Assumes a system clock domain and an external master test clock domain.
// What this block does
// - In configuration mode, take the external serial input on each falling test clock edge in Shift-DR.
// - Update external serial output on falling test clock edges; release it when idle.
// - External master reaches the switch TAP only with configure and request both low.
// - Configure input changes are ignored while the external request is high.
// - Mode select is sampled on rising test clock edges to step the TAP.
// - An asserted external request makes the external port the arbitrated master.
// - Grant zero is low exactly while the external master is arbitrated master.
// - Port-1 clock, data-in, mode-select are inputs as master, outputs as slave.
// - Port-1 data-out is an output as master and an input as slave.
// - Port 1 as master with test reset low enters configuration mode.
// - Port-1 test reset is ignored whenever port 1 is not the master.
// - Port-1 test reset never passes straight to a secondary port reset.
// - Port-1 test reset pin is an input as master, an output as slave.
// - Port 1 becomes master on its request while the external request is inactive.
// - Grant one is low exactly while port 1 is the arbitrated master.
package jms_pkg;

  // Depth of every synchroniser
  localparam int SYNC_STAGES = 2;
  // Width of the switch TAP data register
  localparam int DR_WIDTH = 8;
  // Width of the port-1 pin group
  localparam int PIN_WIDTH = 4;
  // Width of the synchronised pin bundle in the system domain
  localparam int SYS_SYNC_WIDTH = 8;
  // Reset value of a released active-low pin
  localparam logic PIN_IDLE_N = 1'h1;
  // Reset value of the pin group
  localparam logic [3:0] PINS_RESET = 4'h0;
  // Reset value of the data register
  localparam logic [7:0] DR_RESET = 8'h00;

  // Port-1 pin group that turns round between master and slave mode
  typedef struct packed {
    logic test_clock;
    logic serial_in;
    logic mode_select;
    logic test_reset_n;
  } jms_pins_t;

  // Standard TAP controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jms_tap_state_t;

endpackage

// >>> src/jms_port_select.sv
// Master-side front end of the star switch: arbitration, config entry, port-1 pins.
// Assumes pins arrive asynchronously; user-side drive data is on i_clk.
`timescale 1ns/10ps
module jms_port_select (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ext_master_test_clock,
  input wire logic i_ext_master_serial_in,
  input wire logic i_ext_master_mode_select,
  input wire logic i_ext_master_configure_n,
  input wire logic i_ext_master_request_n,
  output logic o_ext_master_serial_out,
  output logic o_ext_master_serial_out_oe,
  output logic o_grant_zero_n,
  output logic o_grant_one_n,
  input wire logic i_port1_request_n,
  input wire logic i_port1_slave_mode,
  input wire jms_pkg::jms_pins_t i_port1_pins,
  output jms_pkg::jms_pins_t o_port1_pins,
  output jms_pkg::jms_pins_t o_port1_pins_oe,
  input wire logic i_port1_serial_out,
  output logic o_port1_serial_out,
  output logic o_port1_serial_out_oe,
  input wire jms_pkg::jms_pins_t i_slave_drive,
  input wire logic i_port1_return_data,
  output jms_pkg::jms_pins_t o_port1_pins_seen,
  output logic o_port1_return_seen,
  output logic o_ext_config,
  output logic o_port1_config
);

  typedef struct packed {
    logic grant_zero_n;
    logic grant_one_n;
    logic ext_config;
    logic port1_config;
    logic slave;
    jms_pkg::jms_pins_t pins_out;
    jms_pkg::jms_pins_t pins_oe;
    logic port1_serial_out;
    logic port1_serial_out_oe;
    jms_pkg::jms_pins_t pins_seen;
    logic return_seen;
  } jms_sys_t;

  jms_sys_t st;
  jms_sys_t next_st;
  logic ext_master_request_n_n_s;
  logic ext_master_configure_n_n_s;
  logic preq_n_s;
  logic port1_serial_out_s;
  jms_pkg::jms_pins_t pins_s;
  logic [1:0] grant;
  logic [7:0] capture_word;

  // Arbitration: bit 0 external, bit 1 port 1; external request wins
  function automatic logic [1:0] arbitrate(input logic ext_master_request_n_n, input logic preq_n);
    if (!ext_master_request_n_n) begin
      arbitrate = 2'h1;
    end else if (!preq_n) begin
      arbitrate = 2'h2;
    end else begin
      arbitrate = 2'h0;
    end
  endfunction

  // Request, configure and port-1 pins pass two flip-flops; active-low pins reset to their idle high
  jms_sync #(.WIDTH(jms_pkg::SYS_SYNC_WIDTH)) u_pin_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_ext_master_request_n, i_ext_master_configure_n, i_port1_request_n,
              i_port1_serial_out, i_port1_pins}),
    .i_reset_value(8'hE1),
    .o_sync({ext_master_request_n_n_s, ext_master_configure_n_n_s, preq_n_s, port1_serial_out_s, pins_s})
  );

  // Arbitrated master from the synchronised requests
  // Masters keep test clocks idle across request changes, so no clock gets cut
  assign grant = arbitrate(ext_master_request_n_n_s, preq_n_s);

  // Grants, configuration entry and port-1 pin turn-round
  always_comb begin
    next_st = st;
    next_st.slave = i_port1_slave_mode;
    next_st.grant_zero_n = ~grant[0];
    next_st.grant_one_n = ~grant[1];
    // Configure only counts while the external request is low
    next_st.ext_config = grant[0] & ~ext_master_configure_n_n_s;
    // Port-1 reset is read only as master pin and while port 1 holds the grant
    if (grant[1] && !i_port1_slave_mode) begin
      next_st.port1_config = st.port1_config | ~pins_s.test_reset_n;
    end else begin
      next_st.port1_config = 1'h0;
    end
    // Slave mode drives the four pins, master mode listens
    if (i_port1_slave_mode) begin
      next_st.pins_out = i_slave_drive;
      next_st.pins_oe = 4'hF;
      next_st.port1_serial_out = 1'h0;
      next_st.port1_serial_out_oe = 1'h0;
      next_st.pins_seen = jms_pkg::PINS_RESET;
      next_st.return_seen = port1_serial_out_s;
    end else begin
      next_st.pins_out = jms_pkg::PINS_RESET;
      next_st.pins_oe = 4'h0;
      next_st.port1_serial_out = i_port1_return_data;
      next_st.port1_serial_out_oe = 1'h1;
      next_st.pins_seen = pins_s;
      next_st.return_seen = 1'h0;
    end
    // The port-1 reset only reaches the pin-seen bundle and the port-1 config flag, no secondary reset
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '{grant_zero_n: jms_pkg::PIN_IDLE_N, grant_one_n: jms_pkg::PIN_IDLE_N,
              ext_config: 1'h0, port1_config: 1'h0, slave: 1'h0,
              pins_out: jms_pkg::PINS_RESET, pins_oe: jms_pkg::PINS_RESET,
              port1_serial_out: 1'h0, port1_serial_out_oe: 1'h0, pins_seen: jms_pkg::PINS_RESET,
              return_seen: 1'h0};
    end else begin
      st <= next_st;
    end
  end

  // Status word shifted out by the switch TAP
  assign capture_word = {4'h0, st.slave, st.port1_config, ~st.grant_one_n, ~st.grant_zero_n};

  // External master path on its own test clock
  jms_tap u_tap (
    .i_ext_master_test_clock(i_ext_master_test_clock),
    .i_sys_rst(i_sys_rst),
    .i_config_level(st.ext_config),
    .i_capture_word(capture_word),
    .i_ext_master_serial_in(i_ext_master_serial_in),
    .i_ext_master_mode_select(i_ext_master_mode_select),
    .o_ext_master_serial_out(o_ext_master_serial_out),
    .o_ext_master_serial_out_oe(o_ext_master_serial_out_oe)
  );

  // Outputs straight from the state flops
  assign o_grant_zero_n = st.grant_zero_n;
  assign o_grant_one_n = st.grant_one_n;
  assign o_ext_config = st.ext_config;
  assign o_port1_config = st.port1_config;
  assign o_port1_pins = st.pins_out;
  assign o_port1_pins_oe = st.pins_oe;
  assign o_port1_serial_out = st.port1_serial_out;
  assign o_port1_serial_out_oe = st.port1_serial_out_oe;
  assign o_port1_pins_seen = st.pins_seen;
  assign o_port1_return_seen = st.return_seen;

endmodule

// >>> src/jms_sync.sv
// Two-stage level synchroniser for a bundle of bits.
// Assumes each bit is a slow level; wide words must be quasi-static.
`timescale 1ns/10ps
module jms_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  input wire logic [WIDTH-1:0] i_reset_value,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } jms_sync_state_t;

  jms_sync_state_t st;
  jms_sync_state_t next_st;

  // First stage feeds only the second stage; stages hold the input flipped by the reset value
  always_comb begin
    next_st = st;
    next_st.meta = i_async ^ i_reset_value;
    next_st.stable = st.meta;
  end

  // Reset clears the stages, so the output shows the reset value until real levels arrive
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.stable ^ i_reset_value;

endmodule

// >>> src/jms_tap.sv
// Switch TAP controller facing the external master, on its own test clock.
// Assumes the test clock may stop between frames; serial input and mode select are that clock's.
`timescale 1ns/10ps
module jms_tap (
  input wire logic i_ext_master_test_clock,
  input wire logic i_sys_rst,
  input wire logic i_config_level,
  input wire logic [7:0] i_capture_word,
  input wire logic i_ext_master_serial_in,
  input wire logic i_ext_master_mode_select,
  output logic o_ext_master_serial_out,
  output logic o_ext_master_serial_out_oe
);

  typedef struct packed {
    jms_pkg::jms_tap_state_t state;
  } jms_pos_t;

  typedef struct packed {
    logic [jms_pkg::DR_WIDTH-1:0] shift;
    logic tdo;
    logic oe;
  } jms_neg_t;

  jms_pos_t pos;
  jms_pos_t next_pos;
  jms_neg_t neg;
  jms_neg_t next_neg;
  logic cfg_sync;
  logic [7:0] cap_sync;

  // Next TAP state from the current state and mode select
  function automatic jms_pkg::jms_tap_state_t tap_next(input jms_pkg::jms_tap_state_t s,
                                                        input logic tms);
    case (s)
      jms_pkg::TAP_RESET: tap_next = tms ? jms_pkg::TAP_RESET : jms_pkg::TAP_IDLE;
      jms_pkg::TAP_IDLE: tap_next = tms ? jms_pkg::TAP_SEL_DR : jms_pkg::TAP_IDLE;
      jms_pkg::TAP_SEL_DR: tap_next = tms ? jms_pkg::TAP_SEL_IR : jms_pkg::TAP_CAP_DR;
      jms_pkg::TAP_CAP_DR: tap_next = tms ? jms_pkg::TAP_EXIT1_DR : jms_pkg::TAP_SHIFT_DR;
      jms_pkg::TAP_SHIFT_DR: tap_next = tms ? jms_pkg::TAP_EXIT1_DR : jms_pkg::TAP_SHIFT_DR;
      jms_pkg::TAP_EXIT1_DR: tap_next = tms ? jms_pkg::TAP_UPD_DR : jms_pkg::TAP_PAUSE_DR;
      jms_pkg::TAP_PAUSE_DR: tap_next = tms ? jms_pkg::TAP_EXIT2_DR : jms_pkg::TAP_PAUSE_DR;
      jms_pkg::TAP_EXIT2_DR: tap_next = tms ? jms_pkg::TAP_UPD_DR : jms_pkg::TAP_SHIFT_DR;
      jms_pkg::TAP_UPD_DR: tap_next = tms ? jms_pkg::TAP_SEL_DR : jms_pkg::TAP_IDLE;
      jms_pkg::TAP_SEL_IR: tap_next = tms ? jms_pkg::TAP_RESET : jms_pkg::TAP_CAP_IR;
      jms_pkg::TAP_CAP_IR: tap_next = tms ? jms_pkg::TAP_EXIT1_IR : jms_pkg::TAP_SHIFT_IR;
      jms_pkg::TAP_SHIFT_IR: tap_next = tms ? jms_pkg::TAP_EXIT1_IR : jms_pkg::TAP_SHIFT_IR;
      jms_pkg::TAP_EXIT1_IR: tap_next = tms ? jms_pkg::TAP_UPD_IR : jms_pkg::TAP_PAUSE_IR;
      jms_pkg::TAP_PAUSE_IR: tap_next = tms ? jms_pkg::TAP_EXIT2_IR : jms_pkg::TAP_PAUSE_IR;
      jms_pkg::TAP_EXIT2_IR: tap_next = tms ? jms_pkg::TAP_UPD_IR : jms_pkg::TAP_SHIFT_IR;
      jms_pkg::TAP_UPD_IR: tap_next = tms ? jms_pkg::TAP_SEL_DR : jms_pkg::TAP_IDLE;
      default: tap_next = jms_pkg::TAP_RESET;
    endcase
  endfunction

  // Configuration level and capture word enter the test clock domain
  jms_sync #(.WIDTH(1 + jms_pkg::DR_WIDTH)) u_cfg_sync (
    .i_clk(i_ext_master_test_clock),
    .i_sys_rst(i_sys_rst),
    .i_async({i_config_level, i_capture_word}),
    .i_reset_value(9'h000),
    .o_sync({cfg_sync, cap_sync})
  );

  // TAP stepping; held in reset outside configuration mode
  always_comb begin
    next_pos = pos;
    if (!cfg_sync) begin
      next_pos.state = jms_pkg::TAP_RESET;
    end else begin
      next_pos.state = tap_next(pos.state, i_ext_master_mode_select);
    end
  end

  always_ff @(posedge i_ext_master_test_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pos <= '{state: jms_pkg::TAP_RESET};
    end else begin
      pos <= next_pos;
    end
  end

  // Falling-edge data path: load, shift in, drive out
  always_comb begin
    next_neg = neg;
    next_neg.oe = cfg_sync && (pos.state == jms_pkg::TAP_SHIFT_DR);
    if (cfg_sync && pos.state == jms_pkg::TAP_CAP_DR) begin
      next_neg.shift = cap_sync;
    end else if (cfg_sync && pos.state == jms_pkg::TAP_SHIFT_DR) begin
      next_neg.tdo = neg.shift[0];
      next_neg.shift = {i_ext_master_serial_in, neg.shift[7:1]};
    end
  end

  always_ff @(negedge i_ext_master_test_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      neg <= '{shift: jms_pkg::DR_RESET, tdo: 1'h0, oe: 1'h0};
    end else begin
      neg <= next_neg;
    end
  end

  assign o_ext_master_serial_out = neg.tdo;
  assign o_ext_master_serial_out_oe = neg.oe;

endmodule

// >>> testbench/jms_ext_master.sv
// Model of the external test master on the configuration port.
// Assumes the test clock stands low between frames; the data-out line has a pull-up.
`timescale 1ns/10ps
module jms_ext_master (
  input wire logic i_serial_out,
  input wire logic i_serial_out_oe,
  output logic o_test_clock,
  output logic o_mode_select,
  output logic o_serial_in
);
  logic line;
  // Released data-out line settles to its pull-up
  assign line = i_serial_out_oe ? i_serial_out : 1'h1;
  // Clock idle low outside frames
  initial begin
    o_test_clock = 1'h0;
    o_mode_select = 1'h1;
    o_serial_in = 1'h0;
  end
  // One 12 ns period; inputs set while low, data-out read at the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
    #2 o_mode_select = tms;
    o_serial_in = tdi;
    #4 o_test_clock = 1'h1;
    tdo = line;
    oe = i_serial_out_oe;
    #6 o_test_clock = 1'h0;
  endtask
  // Idle, enter Shift-DR, shift 16 bits LSB first, back to Idle
  // The device takes data on the falling edge of the tick that enters Shift-DR,
  // so each input bit is presented one tick ahead of the output bit it pairs with
  task automatic dr_frame(input logic [15:0] tdi, output logic [15:0] tdo,
    output logic [15:0] oe, output logic rel);
    logic d;
    logic [15:0] ahead;
    ahead = tdi >> 1;
    for (int i = 0; i < 4; i++) tick(1'h0, 1'h0, d, rel);
    tick(1'h1, 1'h0, d, rel);
    tick(1'h0, 1'h0, d, rel);
    tick(1'h0, tdi[0], d, rel);
    for (int i = 0; i < 16; i++) tick(i == 15, ahead[i], tdo[i], oe[i]);
    tick(1'h1, 1'h0, d, rel);
    tick(1'h0, 1'h0, d, d);
  endtask
endmodule

// >>> testbench/jms_port_select_bench.sv
// Bench for the port select block: arbitration, config entry, TAP shift, port-1 pins.
// Assumes the external master model and the bound checker.
`timescale 1ns/10ps
module jms_port_select_bench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ext_master_request_n_n = 1'h1;
  logic ext_master_configure_n_n = 1'h1;
  logic p1req_n = 1'h1;
  logic slave = 1'h0;
  logic ret = 1'h0;
  logic port1_serial_out_drv = 1'h0;
  logic [3:0] p1_in = 4'hF;
  logic [3:0] drv = 4'h0;
  logic [3:0] p1_out, p1_oe, p1_w, seen;
  logic tck, tms, tdi, tdo, tdo_oe, g0, g1, p1_tdo, p1_tdo_oe, p1_tdo_w, ret_seen, ext_master_configure_n, p1cfg;
  int error_cnt = 0;
  int n_compared = 0;
  // Resolved port-1 lines from both drivers
  assign p1_w = (p1_out & p1_oe) | (p1_in & ~p1_oe);
  assign p1_tdo_w = p1_tdo_oe ? p1_tdo : port1_serial_out_drv;
  always #5 clk = ~clk;
  jms_ext_master i_master (.i_serial_out(tdo), .i_serial_out_oe(tdo_oe), .o_test_clock(tck),
    .o_mode_select(tms), .o_serial_in(tdi));
  jms_port_select i_dut (.i_clk(clk), .i_sys_rst(rst), .i_ext_master_test_clock(tck),
    .i_ext_master_serial_in(tdi), .i_ext_master_mode_select(tms),
    .i_ext_master_configure_n(ext_master_configure_n_n), .i_ext_master_request_n(ext_master_request_n_n),
    .o_ext_master_serial_out(tdo), .o_ext_master_serial_out_oe(tdo_oe), .o_grant_zero_n(g0),
    .o_grant_one_n(g1), .i_port1_request_n(p1req_n), .i_port1_slave_mode(slave),
    .i_port1_pins(p1_w), .o_port1_pins(p1_out), .o_port1_pins_oe(p1_oe),
    .i_port1_serial_out(p1_tdo_w), .o_port1_serial_out(p1_tdo),
    .o_port1_serial_out_oe(p1_tdo_oe), .i_slave_drive(drv), .i_port1_return_data(ret),
    .o_port1_pins_seen(seen), .o_port1_return_seen(ret_seen), .o_ext_config(ext_master_configure_n),
    .o_port1_config(p1cfg));
  // Compare one result and count it
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask
  // External request beats port 1; configure opens the switch TAP
  task automatic t_ext();
    logic [15:0] so, oe;
    logic rel;
    chk("idle grants", 16'h3, {g1, g0});
    ext_master_configure_n_n <= 1'h0;
    settle();
    chk("config no request", 16'h0, ext_master_configure_n);
    ext_master_configure_n_n <= 1'h1;
    ext_master_request_n_n <= 1'h0;
    p1req_n <= 1'h0;
    settle();
    chk("grants", 16'h2, {g1, g0});
    i_master.dr_frame(16'hA55A, so, oe, rel);
    chk("refused shift", 16'hFFFF, so);
    @(posedge clk);
    ext_master_configure_n_n <= 1'h0;
    settle();
    chk("ext config", 16'h1, ext_master_configure_n);
    i_master.dr_frame(16'hA55A, so, oe, rel);
    chk("shift out", 16'h5A01, so);
    chk("shift enable", 16'hFFFF, oe);
    chk("released", 16'h0, rel);
    @(posedge clk);
    ext_master_request_n_n <= 1'h1;
    ext_master_configure_n_n <= 1'h1;
    settle();
    chk("grants", 16'h1, {g1, g0});
  endtask
  // Port-1 test reset opens config only while port 1 holds the grant
  task automatic t_port1();
    p1_in <= 4'hE;
    settle();
    chk("port1 config", 16'h1, p1cfg);
    chk("pins seen", 16'hE, seen);
    p1req_n <= 1'h1;
    settle();
    chk("port1 config", 16'h0, p1cfg);
    chk("grants", 16'h3, {g1, g0});
    p1_in <= 4'hF;
  endtask
  // Port-1 pins turn round between master and slave mode
  task automatic t_pins();
    ret <= 1'h1;
    settle();
    chk("master enables", 16'h1, {p1_oe, p1_tdo_oe});
    chk("data-out", 16'h1, p1_tdo_w);
    slave <= 1'h1;
    drv <= 4'h6;
    port1_serial_out_drv <= 1'h1;
    settle();
    chk("slave enables", 16'h1E, {p1_oe, p1_tdo_oe});
    chk("slave pins", 16'h6, p1_w);
    chk("return seen", 16'h1, ret_seen);
    slave <= 1'h0;
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    settle();
    t_ext();
    t_port1();
    t_pins();
    settle();
    report_and_stop();
  end
endmodule

// >>> testbench/jms_port_select_sva.sv
// Checker for the port select block: arbitration, config entry, port-1 turnaround.
// Assumes request pins sit idle during reset; bound to the top module.
`timescale 1ns/10ps
module jms_port_select_sva (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ext_master_configure_n,
  input wire logic i_ext_master_request_n,
  input wire logic i_port1_request_n,
  input wire logic i_port1_slave_mode,
  input wire logic o_grant_zero_n,
  input wire logic o_grant_one_n,
  input wire jms_pkg::jms_pins_t o_port1_pins_oe,
  input wire logic o_port1_serial_out_oe,
  input wire logic o_ext_config,
  input wire logic o_port1_config
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Grants follow the requests three clock edges later
  a_ext_grant_on: assert property (!i_ext_master_request_n [*4] |-> !o_grant_zero_n)
    else $error("grant zero not given");
  a_ext_grant_off: assert property (i_ext_master_request_n [*4] |-> o_grant_zero_n)
    else $error("grant zero not withdrawn");
  a_p1_grant_on: assert property ((i_ext_master_request_n && !i_port1_request_n) [*4]
    |-> !o_grant_one_n) else $error("grant one not given");
  a_p1_grant_off: assert property ((!i_ext_master_request_n || i_port1_request_n) [*4]
    |-> o_grant_one_n) else $error("grant one held wrongly");
  // Config entry needs both external pins low
  a_cfg_entry: assert property ((!i_ext_master_request_n && !i_ext_master_configure_n) [*4]
    |-> o_ext_config) else $error("config not entered");
  a_cfg_ignored: assert property (i_ext_master_request_n [*4] |-> !o_ext_config)
    else $error("config without request");
  a_p1cfg_grant: assert property (o_port1_config |-> !o_grant_one_n)
    else $error("port1 config without grant");
  a_slave_turn: assert property (i_port1_slave_mode [*2]
    |-> o_port1_pins_oe == 4'hF && !o_port1_serial_out_oe) else $error("slave turnaround");
  c_ext_cfg: cover property (!o_ext_config ##1 o_ext_config);
  c_p1_cfg: cover property (!o_port1_config ##1 o_port1_config);
  c_p1_grant: cover property (o_grant_one_n ##1 !o_grant_one_n);
endmodule
bind jms_port_select jms_port_select_sva i_sva (.i_clk, .i_sys_rst, .i_ext_master_configure_n,
  .i_ext_master_request_n, .i_port1_request_n, .i_port1_slave_mode, .o_grant_zero_n,
  .o_grant_one_n, .o_port1_pins_oe, .o_port1_serial_out_oe, .o_ext_config, .o_port1_config);
